//--- test/asfd_codec_model.sv
`timescale 1ns/1ns
module asfd_codec_model (
    input  wire logic lclk,
    input  wire logic tx_pin,
    input  wire logic tx_pin_oe,
    output logic      frame_sync,
    output logic      rx_pin
);
    logic [15:0] got = 16'h0000;
    int          n_got = 0;
    initial begin
        frame_sync = 1'b0;
        rx_pin = 1'b0;
    end
    // Only bits the device really drives are taken
    always @(negedge lclk) begin
        if (tx_pin_oe === 1'b1) begin
            got <= {got[14:0], tx_pin};
            n_got <= n_got + 1;
        end
    end
    // Sync for one bit period, then MSB first
    task automatic frame(input logic [15:0] w, input int nb);
        @(posedge lclk);
        frame_sync <= 1'b1;
        @(posedge lclk);
        frame_sync <= 1'b0;
        for (int i = nb - 1; i >= 0; i--) begin
            rx_pin <= w[i];
            @(posedge lclk);
        end
        rx_pin <= ~w[0];
    endtask
endmodule

//--- test/asfd_core_asserts.sv
`timescale 1ns/1ns
module asfd_core_asserts (
    input wire logic                       mclk,
    input wire logic                       rst_n,
    input wire logic                       enable,
    input wire logic [asfd_pkg::IP_N-1:0]  irq_en,
    input wire logic [asfd_pkg::IP_N-1:0]  pend_clr,
    input wire logic                       rx_fifo_rd_en,
    input wire logic [asfd_pkg::PTR_W-1:0] tx_warn_limit,
    input wire logic [asfd_pkg::PTR_W-1:0] rx_warn_limit,
    input wire logic [asfd_pkg::CNT_W-1:0] tx_fifo_count,
    input wire logic [asfd_pkg::CNT_W-1:0] rx_fifo_count,
    input wire logic                       rx_overrun_flag,
    input wire logic                       rx_warn_pending,
    input wire logic                       tx_underrun_flag,
    input wire logic                       tx_warn_pending,
    input wire logic                       irq,
    input wire logic                       tx_data_pin_oe
);
    import asfd_pkg::*;
    logic [IP_N-1:0] pend;
    assign pend = {tx_warn_pending, tx_underrun_flag, rx_warn_pending, rx_overrun_flag};
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    chk_irq_raise: assert property (|(pend & irq_en) |-> ##[0:2] irq)
        else $error("irq missing");
    chk_irq_quiet: assert property ((!(|(pend & irq_en))) [*3] |-> !irq)
        else $error("irq without cause");
    chk_txu_hold: assert property (tx_underrun_flag && !pend_clr[IP_TXU] |=> tx_underrun_flag)
        else $error("underrun flag dropped");
    chk_rxo_hold: assert property (rx_overrun_flag && !pend_clr[IP_RXO] |=> rx_overrun_flag)
        else $error("overrun flag dropped");
    chk_full_keep: assert property (rx_fifo_count == CNT_FULL && !rx_fifo_rd_en
        |=> rx_fifo_count == CNT_FULL)
        else $error("full receive fifo changed");
    chk_rx_warn: assert property (enable [*4] ##0 (rx_fifo_count > rx_warn_limit)
        |-> ##[0:3] rx_warn_pending)
        else $error("receive warning missing");
    chk_tx_warn: assert property (enable [*4] ##0 (tx_fifo_count <= tx_warn_limit)
        |-> ##[0:3] tx_warn_pending)
        else $error("transmit warning missing");
    chk_pin_idle: assert property (!enable [*8] |-> !tx_data_pin_oe)
        else $error("pin driven while idle");
endmodule

//--- test/tb_asfd_core.sv
`timescale 1ns/1ns
module tb_asfd_core;
    logic        mclk = 1'b0, lclk = 1'b0, rst_n = 1'b0, enable = 1'b0;
    logic        net_mode = 1'b0, word16 = 1'b0, sync_mode = 1'b0;
    logic        tx_fifo_wr_en = 1'b0, rx_fifo_rd_en = 1'b0, tx_dma_wr_en = 1'b0;
    logic        rx_dma_rd_en = 1'b0;
    logic [1:0]  slots_m1 = 2'h0, tx_dma_wr_slot = 2'h0, rx_dma_rd_slot = 2'h0;
    logic [3:0]  tx_slot_assign = 4'h1, rx_slot_assign = 4'h1, tx_dma_sel = 4'h0;
    logic [3:0]  rx_dma_sel = 4'h0, irq_en = 4'h0, pend_clr = 4'h0, tx_dma_req, rx_dma_req;
    logic [15:0] tx_fifo_wr_data = 16'h0000, tx_dma_wr_data = 16'h0000;
    logic [15:0] rx_fifo_rd_data, rx_dma_rd_data;
    logic [4:0]  tx_fifo_count, rx_fifo_count;
    logic        rx_overrun_flag, rx_warn_pending, tx_underrun_flag, tx_warn_pending, irq;
    logic        tx_data_pin_o, tx_data_pin_oe, fs, rx_data_pin, bit_clk_o, bit_clk_oe;
    logic        int_frame_sync = 1'b0, int_bit_clock = 1'b0, tx_frame_sync_oe;
    int          fails = 0, n_checks = 0, n0;
    initial forever #50 mclk = ~mclk;
    initial begin
        #7;
        forever #24 lclk = ~lclk;
    end
    asfd_core uut (.mclk, .rst_n, .lclk, .enable, .net_mode, .slots_m1, .word16,
        .int_frame_sync, .int_bit_clock, .sync_mode, .tx_slot_assign,
        .rx_slot_assign, .tx_dma_sel, .rx_dma_sel, .tx_warn_limit(4'h0),
        .rx_warn_limit(4'h3), .irq_en, .pend_clr, .tx_fifo_wr_en, .tx_fifo_wr_data,
        .rx_fifo_rd_en, .rx_fifo_rd_data, .tx_dma_wr_en, .tx_dma_wr_slot, .tx_dma_wr_data,
        .tx_dma_req, .rx_dma_rd_en, .rx_dma_rd_slot, .rx_dma_rd_data, .rx_dma_req,
        .tx_fifo_count, .rx_fifo_count, .rx_overrun_flag, .rx_warn_pending,
        .tx_underrun_flag, .tx_warn_pending, .irq, .tx_frame_sync_i(fs),
        .tx_frame_sync_o(), .tx_frame_sync_oe, .rx_frame_sync_i(fs), .rx_data_pin,
        .tx_data_pin_o, .tx_data_pin_oe, .bit_clk_o, .bit_clk_oe);
    asfd_codec_model codec (.lclk, .tx_pin(tx_data_pin_o), .tx_pin_oe(tx_data_pin_oe),
        .frame_sync(fs), .rx_pin(rx_data_pin));
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic push(input logic [15:0] d);
        @(posedge mclk);
        tx_fifo_wr_en <= 1'b1;
        tx_fifo_wr_data <= d;
        @(posedge mclk);
        tx_fifo_wr_en <= 1'b0;
    endtask
    task automatic pop(input logic [15:0] exp);
        @(posedge mclk);
        rx_fifo_rd_en <= 1'b1;
        @(posedge mclk);
        rx_fifo_rd_en <= 1'b0;
        @(negedge mclk);
        check(rx_fifo_rd_data, exp);
    endtask
    task automatic xfer(input logic [15:0] w, input int nb);
        codec.frame(w, nb);
        cyc(10);
        @(negedge mclk);
    endtask
    // Link side resyncs enable, so let it settle
    task automatic en(input logic v);
        @(posedge mclk);
        enable <= v;
        cyc(10);
        @(negedge mclk);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #1000000;
        fails++;
        give_verdict();
    end
    initial begin
        cyc(12);
        rst_n <= 1'b1;
        irq_en <= 4'h4;
        cyc(4);
        @(negedge mclk);
        check({tx_fifo_count, rx_fifo_count, irq}, 16'h0000);
        en(1'b1);
        push(16'h12c3);
        push(16'h34a6);
        cyc(4);
        @(negedge mclk);
        check(tx_fifo_count, 16'h0001);
        n0 = codec.n_got;
        xfer(16'h005a, 8);
        check(codec.got[7:0], 16'h00c3);
        xfer(16'h003c, 8);
        check(codec.got[7:0], 16'h00a6);
        check(tx_underrun_flag, 16'h0000);
        xfer(16'h0099, 8);
        check(codec.got[7:0], 16'h00a6);
        check({tx_underrun_flag, irq}, 16'h0003);
        check(codec.n_got - n0, 16'h0018);
        @(posedge mclk);
        pend_clr <= 4'h4;
        @(posedge mclk);
        pend_clr <= 4'h0;
        cyc(2);
        @(negedge mclk);
        check({tx_underrun_flag, irq}, 16'h0000);
        pop(16'h005a);
        pop(16'h003c);
        pop(16'h0099);
        $display("fifo test done");
        for (int i = 0; i < 17; i++) xfer(16'(i), 8);
        check(rx_fifo_count, 16'h0010);
        check({rx_overrun_flag, rx_warn_pending}, 16'h0003);
        for (int i = 0; i < 16; i++) pop(16'(i));
        $display("overrun test done");
        en(1'b0);
        @(posedge mclk);
        tx_dma_sel <= 4'h1;
        rx_dma_sel <= 4'h1;
        word16 <= 1'b1;
        en(1'b1);
        check(tx_dma_req[0], 16'h0001);
        @(posedge mclk);
        tx_dma_wr_en <= 1'b1;
        tx_dma_wr_data <= 16'ha577;
        @(posedge mclk);
        tx_dma_wr_en <= 1'b0;
        xfer(16'h0011, 16);
        check(rx_dma_req[0], 16'h0001);
        xfer(16'h0022, 16);
        check(codec.got, 16'ha577);
        xfer(16'h5a33, 16);
        check(codec.got, 16'ha577);
        @(posedge mclk);
        rx_dma_rd_en <= 1'b1;
        @(posedge mclk);
        rx_dma_rd_en <= 1'b0;
        @(negedge mclk);
        check(rx_dma_rd_data, 16'h5a33);
        check({rx_dma_req[0], rx_fifo_count}, 16'h0000);
        $display("dma test done");
        en(1'b0);
        @(posedge mclk);
        net_mode <= 1'b1;
        slots_m1 <= 2'h1;
        sync_mode <= 1'b1;
        word16 <= 1'b0;
        tx_slot_assign <= 4'h2;
        rx_slot_assign <= 4'h2;
        tx_dma_sel <= 4'h0;
        rx_dma_sel <= 4'h0;
        en(1'b1);
        push(16'h00e1);
        cyc(5);
        n0 = codec.n_got;
        xfer(16'h55aa, 16);
        check(codec.n_got - n0, 16'h0008);
        check(codec.got[7:0], 16'h00e1);
        check(rx_fifo_count, 16'h0001);
        pop(16'h00aa);
        $display("network test done");
        en(1'b0);
        @(posedge mclk);
        int_frame_sync <= 1'b1;
        int_bit_clock <= 1'b1;
        cyc(2);
        @(negedge mclk);
        check({tx_frame_sync_oe, bit_clk_oe, bit_clk_o}, 16'h0007);
        cyc(2);
        @(negedge mclk);
        check(bit_clk_o, 16'h0000);
        $display("clock test done");
        give_verdict();
    end
endmodule
bind asfd_core asfd_core_asserts chk (.mclk, .rst_n, .enable, .irq_en, .pend_clr,
    .rx_fifo_rd_en, .tx_warn_limit, .rx_warn_limit, .tx_fifo_count, .rx_fifo_count,
    .rx_overrun_flag, .rx_warn_pending, .tx_underrun_flag, .tx_warn_pending, .irq,
    .tx_data_pin_oe);

//--- verilog/asfd_core.sv
// Overview of operation
// - Four causes merge into one interrupt request
// - Normal mode: one slot, 8-bit in low byte
// - Frame sync starts transmit; shift on rising edge
// - Normal DMA transmit reloads slot 0, resends
// - FIFO transmit loads at read pointer, increments
// - Transmit FIFO write stores at write pointer
// - Equal pointers: last read empty, write full
// - Transmit underrun resends previous word, sets flag
// - Frame sync, bit clock internal or external
// - Receive shifts on falling edge; sync mode
// - Normal DMA receive overwrites slot 0 register
// - FIFO receive stores at write pointer, increments
// - Receive FIFO read returns entry, increments pointer
// - Full receive FIFO discards word, sets overrun
// - Network mode frames hold up to four slots
// - Transmit pin driven only in assigned slots
// - Network DMA transmit per slot register, resend
// - Successive assigned slots take successive FIFO entries
// - Only assigned receive slots are transferred
// - Network DMA receive per slot, overwrite
// - Receive warning when fill exceeds limit
// - Transmit warning when fill at or below limit
// - Receive destination selectable per slot
`timescale 1ns/1ns
module asfd_core (
    input  wire logic                            mclk,
    input  wire logic                            rst_n,
    input  wire logic                            lclk,
    input  wire logic                            enable,
    input  wire logic                            net_mode,
    input  wire logic [asfd_pkg::SLOT_W-1:0]     slots_m1,
    input  wire logic                            word16,
    input  wire logic                            int_frame_sync,
    input  wire logic                            int_bit_clock,
    input  wire logic                            sync_mode,
    input  wire logic [asfd_pkg::SLOT_N-1:0]     tx_slot_assign,
    input  wire logic [asfd_pkg::SLOT_N-1:0]     rx_slot_assign,
    input  wire logic [asfd_pkg::SLOT_N-1:0]     tx_dma_sel,
    input  wire logic [asfd_pkg::SLOT_N-1:0]     rx_dma_sel,
    input  wire logic [asfd_pkg::PTR_W-1:0]      tx_warn_limit,
    input  wire logic [asfd_pkg::PTR_W-1:0]      rx_warn_limit,
    input  wire logic [asfd_pkg::IP_N-1:0]       irq_en,
    input  wire logic [asfd_pkg::IP_N-1:0]       pend_clr,
    input  wire logic                            tx_fifo_wr_en,
    input  wire logic [asfd_pkg::WORD_W-1:0]     tx_fifo_wr_data,
    input  wire logic                            rx_fifo_rd_en,
    output logic      [asfd_pkg::WORD_W-1:0]     rx_fifo_rd_data,
    input  wire logic                            tx_dma_wr_en,
    input  wire logic [asfd_pkg::SLOT_W-1:0]     tx_dma_wr_slot,
    input  wire logic [asfd_pkg::WORD_W-1:0]     tx_dma_wr_data,
    output logic      [asfd_pkg::SLOT_N-1:0]     tx_dma_req,
    input  wire logic                            rx_dma_rd_en,
    input  wire logic [asfd_pkg::SLOT_W-1:0]     rx_dma_rd_slot,
    output logic      [asfd_pkg::WORD_W-1:0]     rx_dma_rd_data,
    output logic      [asfd_pkg::SLOT_N-1:0]     rx_dma_req,
    output logic      [asfd_pkg::CNT_W-1:0]      tx_fifo_count,
    output logic      [asfd_pkg::CNT_W-1:0]      rx_fifo_count,
    output logic                                 rx_overrun_flag,
    output logic                                 rx_warn_pending,
    output logic                                 tx_underrun_flag,
    output logic                                 tx_warn_pending,
    output logic                                 irq,
    input  wire logic                            tx_frame_sync_i,
    output logic                                 tx_frame_sync_o,
    output logic                                 tx_frame_sync_oe,
    input  wire logic                            rx_frame_sync_i,
    input  wire logic                            rx_data_pin,
    output logic                                 tx_data_pin_o,
    output logic                                 tx_data_pin_oe,
    output logic                                 bit_clk_o,
    output logic                                 bit_clk_oe
);
    import asfd_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][WORD_W-1:0]  tmem;
        logic [DEPTH-1:0][WORD_W-1:0]  rmem;
        logic [PTR_W-1:0]              tx_fifo_read_ptr;
        logic [PTR_W-1:0]              tx_fifo_write_ptr;
        logic [PTR_W-1:0]              rx_fifo_read_ptr;
        logic [PTR_W-1:0]              rx_fifo_write_ptr;
        logic                          tlw;
        logic                          rlw;
        logic [SLOT_N-1:0][WORD_W-1:0] tstg;
        logic [SLOT_N-1:0][WORD_W-1:0] tdma;
        logic [SLOT_N-1:0][WORD_W-1:0] rdma;
        logic [SLOT_N-1:0]             req;
        logic [SLOT_N-1:0]             tdma_full;
        logic [SLOT_N-1:0]             rdma_full;
        logic [SLOT_N-1:0]             ack_m;
        logic [SLOT_N-1:0]             ack_s;
        logic [SLOT_N-1:0]             rxt_m;
        logic [SLOT_N-1:0]             rxt_s;
        logic [SLOT_N-1:0]             rxt_d;
        logic                          urun_m;
        logic                          urun_s;
        logic                          urun_d;
        logic [IP_N-1:0]               pend;
        logic                          irq;
        logic [WORD_W-1:0]             rd_data;
        logic [WORD_W-1:0]             dma_rd_data;
        logic [CNT_W-1:0]              tcnt;
        logic [CNT_W-1:0]              rcnt;
        logic [SLOT_N-1:0]             tdma_req;
        logic [SLOT_N-1:0]             rdma_req;
        logic [DIV_W-1:0]              div;
        logic                          bclk;
        logic                          bclk_oe;
    } asfd_core_s;

    typedef struct packed {
        logic                          rs_m;
        logic                          rs_s;
        logic [CFG_W-1:0]              cfg_m;
        logic [CFG_W-1:0]              cfg_s;
        logic [SLOT_N-1:0]             req_m;
        logic [SLOT_N-1:0]             req_s;
        asfd_link_e                    st;
        logic [BIT_W-1:0]              bitc;
        logic [SLOT_W-1:0]             slot;
        logic [WORD_W-1:0]             sh;
        logic [SLOT_N-1:0][WORD_W-1:0] lst;
        logic [SLOT_N-1:0]             ack;
        logic                          urun;
        logic                          d_o;
        logic                          d_oe;
        logic                          fs_o;
        logic                          fs_oe;
    } asfd_tx_s;

    typedef struct packed {
        asfd_link_e                    st;
        logic [BIT_W-1:0]              bitc;
        logic [SLOT_W-1:0]             slot;
        logic [WORD_W-1:0]             sh;
        logic [SLOT_N-1:0][WORD_W-1:0] stg;
        logic [SLOT_N-1:0]             tog;
    } asfd_rx_s;

    asfd_core_s        c;
    asfd_core_s        n;
    asfd_tx_s          t;
    asfd_tx_s          nt;
    asfd_rx_s          r;
    asfd_rx_s          nr;
    logic [CFG_W-1:0]  cfg;
    logic [SLOT_N-1:0] tx_use;
    logic [SLOT_N-1:0] tx_drv;
    logic [SLOT_N-1:0] rx_take;
    logic              l_en;
    logic              l_net;
    logic              l_w16;
    logic              l_ifs;
    logic [SLOT_W-1:0] l_slm;
    logic [BIT_W-1:0]  l_last;
    logic              l_fs;
    logic              r_fs;

    function automatic logic [CNT_W-1:0] fill(input logic [PTR_W-1:0] wp,
                                              input logic [PTR_W-1:0] rp,
                                              input logic             lw);
        logic [PTR_W-1:0] d;
        d = wp - rp;
        if (wp == rp) begin
            fill = lw ? CNT_FULL : '0;
        end else begin
            fill = {1'b0, d};
        end
    endfunction

    assign cfg = {tx_dma_sel, rx_slot_assign, tx_slot_assign, sync_mode, int_frame_sync,
                  word16, slots_m1, net_mode, enable};

    assign l_en   = t.cfg_s[CF_EN];
    assign l_net  = t.cfg_s[CF_NET];
    assign l_w16  = t.cfg_s[CF_W16];
    assign l_ifs  = t.cfg_s[CF_IFS];
    assign l_slm  = l_net ? t.cfg_s[CF_SLM +: SLOT_W] : SLOT_ZERO;
    assign l_last = l_w16 ? LAST_BIT16 : LAST_BIT8;
    assign l_fs   = l_ifs ? t.fs_o : tx_frame_sync_i;
    assign r_fs   = t.cfg_s[CF_SYNC] ? l_fs : rx_frame_sync_i;

    genvar g;
    generate
        for (g = 0; g < SLOT_N; g++) begin : g_slot
            assign tx_use[g]  = net_mode ? (tx_slot_assign[g] && (SLOT_W'(g) <= slots_m1))
                                         : (g == 0);
            assign tx_drv[g]  = l_net ? (t.cfg_s[CF_TXA + g] && (SLOT_W'(g) <= l_slm))
                                      : (g == 0);
            assign rx_take[g] = l_net ? t.cfg_s[CF_RXA + g] : (g == 0);
        end
    endgenerate

    // Register-side datapath
    always_comb begin
        logic [IP_N-1:0] set;
        logic            found;
        logic            popped;
        logic            ovr;
        logic [WORD_W-1:0] w;
        set    = '0;
        found  = 1'b0;
        popped = 1'b0;
        ovr    = 1'b0;
        w      = '0;
        n      = c;
        n.ack_m  = t.ack;
        n.ack_s  = c.ack_m;
        n.urun_m = t.urun;
        n.urun_s = c.urun_m;
        n.urun_d = c.urun_s;
        n.rxt_m  = r.tog;
        n.rxt_s  = c.rxt_m;
        n.rxt_d  = c.rxt_s;

        // Refill one free per-slot stage per cycle, lowest slot first
        for (int i = 0; i < SLOT_N; i++) begin
            if (!found && enable && tx_use[i] && (c.req[i] == c.ack_s[i])) begin
                if (tx_dma_sel[i]) begin
                    if (c.tdma_full[i]) begin
                        n.tstg[i]      = c.tdma[i];
                        n.tdma_full[i] = 1'b0;
                        n.req[i]       = ~c.req[i];
                        found          = 1'b1;
                    end
                end else if (fill(c.tx_fifo_write_ptr, c.tx_fifo_read_ptr, c.tlw) != '0) begin
                    n.tstg[i] = c.tmem[c.tx_fifo_read_ptr];
                    n.tx_fifo_read_ptr     = c.tx_fifo_read_ptr + PTR_ONE;
                    n.req[i]  = ~c.req[i];
                    popped    = 1'b1;
                    found     = 1'b1;
                end
            end
        end
        if (popped) begin
            n.tlw = 1'b0;
        end
        if (tx_fifo_wr_en) begin
            n.tmem[c.tx_fifo_write_ptr] = tx_fifo_wr_data;
            n.tx_fifo_write_ptr         = c.tx_fifo_write_ptr + PTR_ONE;
            n.tlw         = 1'b1;
        end
        if (tx_dma_wr_en) begin
            n.tdma[tx_dma_wr_slot]      = tx_dma_wr_data;
            n.tdma_full[tx_dma_wr_slot] = 1'b1;
        end
        if (c.urun_s != c.urun_d) begin
            set[IP_TXU] = 1'b1;
        end

        if (rx_fifo_rd_en) begin
            n.rd_data = c.rmem[c.rx_fifo_read_ptr];
            n.rx_fifo_read_ptr     = c.rx_fifo_read_ptr + PTR_ONE;
            n.rlw     = 1'b0;
        end
        if (rx_dma_rd_en) begin
            n.dma_rd_data               = c.rdma[rx_dma_rd_slot];
            n.rdma_full[rx_dma_rd_slot] = 1'b0;
        end
        for (int i = 0; i < SLOT_N; i++) begin
            if (c.rxt_s[i] != c.rxt_d[i]) begin
                w = r.stg[i];
                if (rx_dma_sel[i]) begin
                    n.rdma[i]      = w;
                    n.rdma_full[i] = 1'b1;
                end else if ((n.rx_fifo_write_ptr == n.rx_fifo_read_ptr) && n.rlw) begin
                    ovr          = 1'b1;
                    set[IP_RXO]  = 1'b1;
                end else begin
                    n.rmem[n.rx_fifo_write_ptr] = w;
                    n.rx_fifo_write_ptr         = n.rx_fifo_write_ptr + PTR_ONE;
                    n.rlw         = 1'b1;
                end
            end
        end

        n.tcnt = fill(n.tx_fifo_write_ptr, n.tx_fifo_read_ptr, n.tlw);
        n.rcnt = fill(n.rx_fifo_write_ptr, n.rx_fifo_read_ptr, n.rlw);
        if (enable && !set[IP_TXU] && (n.tcnt <= {1'b0, tx_warn_limit})) begin
            set[IP_TXW] = 1'b1;
        end
        if (enable && !ovr && (n.rcnt > {1'b0, rx_warn_limit})) begin
            set[IP_RXW] = 1'b1;
        end
        n.pend = (c.pend & ~pend_clr) | set;
        n.irq  = |(n.pend & irq_en);

        n.tdma_req = ~n.tdma_full & tx_dma_sel & tx_use & {SLOT_N{enable}};
        n.rdma_req = n.rdma_full;

        n.bclk_oe = int_bit_clock;
        if (int_bit_clock) begin
            if (c.div == BCLK_HALF_M1) begin
                n.div  = '0;
                n.bclk = ~c.bclk;
            end else begin
                n.div = c.div + DIV_ONE;
            end
        end else begin
            n.div  = '0;
            n.bclk = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            c <= '0;
        end else begin
            c <= n;
        end
    end

    // Transmit side of the link, rising bit clock edge
    always_comb begin
        logic              do_load;
        logic [SLOT_W-1:0] ls;
        logic [WORD_W-1:0] w;
        do_load  = 1'b0;
        ls       = SLOT_ZERO;
        w        = '0;
        nt       = t;
        nt.rs_m  = rst_n;
        nt.rs_s  = t.rs_m;
        nt.cfg_m = cfg;
        nt.cfg_s = t.cfg_m;
        nt.req_m = c.req;
        nt.req_s = t.req_m;
        nt.fs_o  = 1'b0;
        nt.fs_oe = l_ifs;
        if (!l_en) begin
            nt.st   = LK_IDLE;
            nt.d_oe = 1'b0;
            nt.d_o  = 1'b0;
        end else if (l_fs) begin
            do_load = 1'b1;
        end else if (t.st == LK_FRAME) begin
            if (t.bitc == l_last) begin
                if (t.slot == l_slm) begin
                    nt.st   = LK_IDLE;
                    nt.d_oe = 1'b0;
                    nt.d_o  = 1'b0;
                end else begin
                    do_load = 1'b1;
                    ls      = t.slot + SLOT_ONE;
                end
            end else begin
                nt.bitc = t.bitc + BIT_ONE;
                nt.d_o  = l_w16 ? t.sh[WORD_W-1] : t.sh[BYTE_W-1];
                nt.sh   = {t.sh[WORD_W-2:0], 1'b0};
            end
            if (l_ifs && (t.slot == l_slm) && (t.bitc == l_last - BIT_ONE)) begin
                nt.fs_o = 1'b1;
            end
        end else if (l_ifs) begin
            nt.fs_o = 1'b1;
        end

        if (do_load) begin
            nt.st   = LK_FRAME;
            nt.slot = ls;
            nt.bitc = '0;
            nt.d_oe = tx_drv[ls];
            w       = t.lst[ls];
            if (tx_drv[ls]) begin
                if (t.req_s[ls] != t.ack[ls]) begin
                    w           = c.tstg[ls];
                    nt.lst[ls]  = w;
                    nt.ack[ls]  = ~t.ack[ls];
                end else if (!t.cfg_s[CF_TXD + int'(ls)]) begin
                    nt.urun = ~t.urun;
                end
            end
            nt.d_o = tx_drv[ls] & (l_w16 ? w[WORD_W-1] : w[BYTE_W-1]);
            nt.sh  = {w[WORD_W-2:0], 1'b0};
        end

        if (!t.rs_s) begin
            nt       = '0;
            nt.rs_m  = rst_n;
            nt.rs_s  = t.rs_m;
            nt.st    = LK_IDLE;
        end
    end

    always_ff @(posedge lclk) begin
        t <= nt;
    end

    // Receive side of the link, falling bit clock edge
    always_comb begin
        logic [WORD_W-1:0] w;
        w  = {r.sh[WORD_W-2:0], rx_data_pin};
        nr = r;
        if (!l_en) begin
            nr.st = LK_IDLE;
        end else begin
            if (r.st == LK_FRAME) begin
                nr.sh = w;
                if (r.bitc == l_last) begin
                    if (!l_w16) begin
                        w = {BYTE_ZERO, w[BYTE_W-1:0]};
                    end
                    if (rx_take[r.slot]) begin
                        nr.stg[r.slot] = w;
                        nr.tog[r.slot] = ~r.tog[r.slot];
                    end
                    nr.bitc = '0;
                    if (r.slot == l_slm) begin
                        nr.st = LK_IDLE;
                    end else begin
                        nr.slot = r.slot + SLOT_ONE;
                    end
                end else begin
                    nr.bitc = r.bitc + BIT_ONE;
                end
            end
            if (r_fs) begin
                nr.st   = LK_FRAME;
                nr.bitc = '0;
                nr.slot = SLOT_ZERO;
            end
        end
        if (!t.rs_s) begin
            nr    = '0;
            nr.st = LK_IDLE;
        end
    end

    always_ff @(negedge lclk) begin
        r <= nr;
    end

    assign rx_fifo_rd_data  = c.rd_data;
    assign rx_dma_rd_data   = c.dma_rd_data;
    assign tx_dma_req       = c.tdma_req;
    assign rx_dma_req       = c.rdma_req;
    assign tx_fifo_count    = c.tcnt;
    assign rx_fifo_count    = c.rcnt;
    assign rx_overrun_flag  = c.pend[IP_RXO];
    assign rx_warn_pending  = c.pend[IP_RXW];
    assign tx_underrun_flag = c.pend[IP_TXU];
    assign tx_warn_pending  = c.pend[IP_TXW];
    assign irq              = c.irq;
    assign tx_frame_sync_o  = t.fs_o;
    assign tx_frame_sync_oe = t.fs_oe;
    assign tx_data_pin_o    = t.d_o;
    assign tx_data_pin_oe   = t.d_oe;
    assign bit_clk_o        = c.bclk;
    assign bit_clk_oe       = c.bclk_oe;

endmodule

//--- verilog/asfd_pkg.sv
package asfd_pkg;

    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int DEPTH  = 16;
    localparam int PTR_W  = 4;
    localparam int CNT_W  = 5;
    localparam int SLOT_N = 4;
    localparam int SLOT_W = 2;
    localparam int BIT_W  = 4;
    localparam int DIV_W  = 4;

    localparam logic [BIT_W-1:0]  LAST_BIT8    = 4'h7;
    localparam logic [BIT_W-1:0]  LAST_BIT16   = 4'hf;
    localparam logic [BIT_W-1:0]  BIT_ONE      = 4'h1;
    localparam logic [SLOT_W-1:0] SLOT_ONE     = 2'h1;
    localparam logic [SLOT_W-1:0] SLOT_ZERO    = 2'h0;
    localparam logic [PTR_W-1:0]  PTR_ONE      = 4'h1;
    localparam logic [CNT_W-1:0]  CNT_FULL     = 5'h10;
    localparam logic [BYTE_W-1:0] BYTE_ZERO    = 8'h00;
    localparam logic [DIV_W-1:0]  BCLK_HALF_M1 = 4'h1;
    localparam logic [DIV_W-1:0]  DIV_ONE      = 4'h1;

    // Pending flag positions
    localparam int IP_N   = 4;
    localparam int IP_RXO = 0;
    localparam int IP_RXW = 1;
    localparam int IP_TXU = 2;
    localparam int IP_TXW = 3;

    // Configuration vector carried into the link domain
    localparam int CF_EN   = 0;
    localparam int CF_NET  = 1;
    localparam int CF_SLM  = 2;
    localparam int CF_W16  = 4;
    localparam int CF_IFS  = 5;
    localparam int CF_SYNC = 6;
    localparam int CF_TXA  = 7;
    localparam int CF_RXA  = 11;
    localparam int CF_TXD  = 15;
    localparam int CFG_W   = 19;

    typedef enum logic [1:0] {
        LK_IDLE  = 2'b01,
        LK_FRAME = 2'b10
    } asfd_link_e;

endpackage
